//--- hw/lcs_consts.svh
// Timing counts, register offsets, field positions and reset values for the loop supervisor
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
`define LCS_CLK_KHZ          125000
`define LCS_TICK_MS          1
`define LCS_TICK_CYCLES      (`LCS_CLK_KHZ * `LCS_TICK_MS)
`define LCS_EXT_RST_MS       30
`define LCS_CHANNEL_SELECT_BUTTON_HOLD_MS     3000
`define LCS_TUNE_MS          2000
`define LCS_FULL_SENS_MS     30000
`define LCS_BACKLIGHT_MS     900000
`define LCS_RESTORE_MS       5000
`define LCS_PULSE_ON_MS      50
`define LCS_OFF_OPEN_MS      50
`define LCS_OFF_SHORT_MS     100
`define LCS_OFF_DL_MS        150
`define LCS_FLASH_MS         100
`define LCS_FLASH_SLOTS      10
`define LCS_FLASH_LIT_SLOTS  6
`define LCS_REG_CTRL         4'h0
`define LCS_REG_CFG          4'h4
`define LCS_REG_STAT         4'h8
`define LCS_REG_TALLY        4'hC
`define LCS_CTRL_NFD_BIT     0
`define LCS_CTRL_DIAG_LSB    1
`define LCS_CFG_CH_W         8
`define LCS_CFG_FIELD_W      7
`define LCS_CTRL_RST         4'h0
`define LCS_CFG_RST          16'h7636
`define LCS_SYNC_RST         7'h07
`endif

//--- hw/lcs_pkg.sv
// Types shared by the loop channel supervisor
package lcs_pkg;
	typedef enum logic [1:0] {
		TUNE_WAIT = 2'b00,
		TUNE_OPER = 2'b01,
		TUNE_FULL = 2'b11
	} lcs_tune_e;
	typedef enum logic [1:0] {
		RS_IDLE  = 2'b00,
		RS_COUNT = 2'b01,
		RS_FIRE  = 2'b11,
		RS_DONE  = 2'b10
	} lcs_restore_e;
endpackage : lcs_pkg

//--- hw/lcs_top.sv
// Loop channel supervisor: resets, fail-safe, status pulses, LEDs, backlight, restore
`timescale 1ns/10ps
// Functional notes
// - Reset input low 30 ms resets both channels; cabinet must hold it that long.
// - Power cycle or noise filter disable toggle gives a full detector reset.
// - Channel select button held 3 s resets only the selected channel.
// - Sensitivity or frequency change of a channel resets that channel alone.
// - Channel reset or noise filter toggle keeps diagnostic enables unchanged.
// - Reset-input or power reset clears all diagnostic enables.
// - Green input low aborts delay timing and gates the green-driven features.
// - Channel output conducts on detection and falls to call on loop failure.
// - Status output low in normal operation, high when detector failed.
// - Status pulses 50 ms on; off 50/100/150 ms for open/short/change.
// - Backlight on at any button press, off 15 minutes after last press.
// - Detect LED shows call, delay, extension, pending or failed loop.
// - Channel operational 2 s after reset, full sensitivity after 30 s.
// - Loop out of range or fast 25 percent change forces fail-safe at once.
// - Low code for minus change or short; high code for plus change or open.
// - Fault shown while present; retune after reset only with loop in range.
// - Fail-safe gives a continuous call in presence and pulse mode alike.
// - Loop failure makes LED burst three flashes each second until reset.
// - Self-healed fault clears message but LED bursts stay latched.
// - Each failure bumps a channel tally, cleared by power or manual reset.
// - All four switches held 5 s restores defaults with countdown; release aborts.
// - Any two switches pressed together light every display segment.
`include "lcs_consts.svh"
module lcs_top
	import lcs_pkg::*;
#(
	parameter int unsigned P_TICK_CYCLES  = `LCS_TICK_CYCLES,
	parameter int unsigned P_FULL_SENS_MS = `LCS_FULL_SENS_MS,
	parameter int unsigned P_BACKLIGHT_MS = `LCS_BACKLIGHT_MS,
	parameter int unsigned P_RESTORE_MS   = `LCS_RESTORE_MS
)(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic        i_ext_reset_n,
	input  wire logic [1:0]  i_phase_green_n,
	input  wire logic [3:0]  i_btn,
	input  wire logic [1:0]  i_loop_detect,
	input  wire logic [1:0]  i_loop_open,
	input  wire logic [1:0]  i_loop_short,
	input  wire logic [1:0]  i_loop_dl_hi,
	input  wire logic [1:0]  i_loop_dl_lo,
	input  wire logic [1:0]  i_det_fail,
	input  wire logic [1:0]  i_delay_active,
	input  wire logic [1:0]  i_ext_active,
	input  wire logic [1:0]  i_pending,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic [1:0]       o_call,
	output logic [1:0]       o_status,
	output logic [1:0]       o_led,
	output logic [1:0]       o_channel_select_button_reset,
	output logic [1:0]       o_delay_abort,
	output logic [1:0]       o_low_fault_code,
	output logic [1:0]       o_high_fault_code,
	output logic [1:0]       o_loop_fail_msg,
	output logic [1:0]       o_operational,
	output logic [1:0]       o_full_sens,
	output logic             o_backlight,
	output logic             o_display_test,
	output logic             o_restore_active,
	output logic [12:0]      o_restore_left_ms
);

	// Off time of the status pulse train for a given fault kind
	function automatic logic [7:0] lcs_off_ms(input logic open_l, input logic short_l);
		if (open_l)
			return 8'(`LCS_OFF_OPEN_MS);
		else if (short_l)
			return 8'(`LCS_OFF_SHORT_MS);
		else
			return 8'(`LCS_OFF_DL_MS);
	endfunction : lcs_off_ms

	// Number of panel switches held
	function automatic logic [2:0] lcs_pop4(input logic [3:0] b);
		return 3'(b[0]) + 3'(b[1]) + 3'(b[2]) + 3'(b[3]);
	endfunction : lcs_pop4

	logic [16:0]  tick_cnt_q;
	logic         tick_q;
	logic [6:0]   sync1_q;
	logic [6:0]   sync2_q;
	logic [3:0]   btn_prev_q;
	logic [3:0]   btn_s;
	logic [1:0]   green_n_s;
	logic         ext_n_s;
	logic [3:0]   btn_rise;
	logic [4:0]   ext_cnt_q;
	logic         ext_fire_q;
	logic [11:0]  hold_cnt_q;
	logic         hold_fire_q;
	logic         sel_q;
	logic         wait_q;
	logic         wr_ok;
	logic         nfd_q;
	logic         nfd_tog_q;
	logic [2:0]   diag_q;
	logic [15:0]  cfg_q;
	logic [1:0]   cfg_chg_q;
	logic [1:0]   ch_rst_q;
	logic         dev_rst;
	logic         restore_fire;
	lcs_restore_e rs_q;
	logic [12:0]  rs_cnt_q;
	lcs_tune_e    tune_q [2];
	logic [14:0]  tune_cnt_q [2];
	logic [1:0]   fault_now;
	logic [1:0]   fault_prev_q;
	logic [1:0]   fault_rise;
	logic [1:0]   pat_any;
	logic [7:0]   pat_cnt_q [2];
	logic [7:0]   tally_q [2];
	logic [1:0]   alert_q;
	logic [6:0]   flash_cnt_q;
	logic [3:0]   flash_slot_q;
	logic         burst_on;
	logic [19:0]  bl_cnt_q;

	assign btn_s        = sync2_q[6:3];
	assign green_n_s    = sync2_q[2:1];
	assign ext_n_s      = sync2_q[0];
	assign btn_rise     = btn_s & ~btn_prev_q;
	assign wr_ok        = i_avs_write && !wait_q;
	assign restore_fire = (rs_q == RS_FIRE);
	assign dev_rst      = ext_fire_q | nfd_tog_q | restore_fire;
	assign burst_on     = (flash_slot_q < 4'(`LCS_FLASH_LIT_SLOTS)) && !flash_slot_q[0];
	assign o_avs_waitrequest = wait_q;

	// Per-channel fault decode; same-clock inputs act in the next cycle
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			fault_now[c]  = i_loop_open[c] | i_loop_short[c] | i_loop_dl_hi[c] | i_loop_dl_lo[c];
			fault_rise[c] = fault_now[c] & ~fault_prev_q[c];
			pat_any[c]    = fault_now[c] & ~i_det_fail[c];
		end
	end

	// Free-running millisecond tick
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tick_cnt_q <= 17'h0_0000;
			tick_q     <= 1'b0;
		end
		else if (i_ce)
		begin
			tick_q <= (tick_cnt_q == 17'(P_TICK_CYCLES - 1));
			if (tick_cnt_q == 17'(P_TICK_CYCLES - 1))
				tick_cnt_q <= 17'h0_0000;
			else
				tick_cnt_q <= tick_cnt_q + 17'h0_0001;
		end
	end

	// Pin synchronisers; only the second stage is read
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_q    <= `LCS_SYNC_RST;
			sync2_q    <= `LCS_SYNC_RST;
			btn_prev_q <= 4'h0;
		end
		else if (i_ce)
		begin
			sync1_q    <= {i_btn, i_phase_green_n, i_ext_reset_n};
			sync2_q    <= sync1_q;
			btn_prev_q <= btn_s;
		end
	end

	// Reset input qualifier: one reset per low period of 30 ms or longer
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ext_cnt_q  <= 5'h00;
			ext_fire_q <= 1'b0;
		end
		else if (i_ce)
		begin
			ext_fire_q <= !ext_n_s && tick_q && (ext_cnt_q == 5'(`LCS_EXT_RST_MS - 1));
			if (ext_n_s)
				ext_cnt_q <= 5'h00;
			else if (tick_q && ext_cnt_q != 5'(`LCS_EXT_RST_MS))
				ext_cnt_q <= ext_cnt_q + 5'h01;
		end
	end

	// Channel select: each press moves the selection, a long hold resets the selected channel
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sel_q       <= 1'b0;
			hold_cnt_q  <= 12'h000;
			hold_fire_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (btn_rise[0])
				sel_q <= ~sel_q;
			hold_fire_q <= btn_s[0] && tick_q &&
				(hold_cnt_q == 12'(`LCS_CHANNEL_SELECT_BUTTON_HOLD_MS - 1));
			if (!btn_s[0])
				hold_cnt_q <= 12'h000;
			else if (tick_q && hold_cnt_q != 12'(`LCS_CHANNEL_SELECT_BUTTON_HOLD_MS))
				hold_cnt_q <= hold_cnt_q + 12'h001;
		end
	end

	// Avalon slave handshake: waitrequest drops for one cycle per request
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_q         <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end
		else if (i_ce)
		begin
			wait_q <= !(wait_q && (i_avs_read || i_avs_write));
			if (i_avs_read && wait_q)
			begin
				case (i_avs_address)
					`LCS_REG_CTRL:  o_avs_readdata <= {28'h000_0000, diag_q, nfd_q};
					`LCS_REG_CFG:   o_avs_readdata <= {16'h0000, cfg_q};
					`LCS_REG_STAT:  o_avs_readdata <= {22'h00_0000, o_backlight, sel_q,
						o_full_sens, o_operational, alert_q, o_loop_fail_msg};
					`LCS_REG_TALLY: o_avs_readdata <= {16'h0000, tally_q[1], tally_q[0]};
					default:        o_avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control and configuration registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			nfd_q     <= 1'b0;
			diag_q    <= 3'h0;
			cfg_q     <= `LCS_CFG_RST;
			nfd_tog_q <= 1'b0;
			cfg_chg_q <= 2'h0;
		end
		else if (i_ce)
		begin
			nfd_tog_q <= wr_ok && (i_avs_address == `LCS_REG_CTRL) &&
				(i_avs_writedata[`LCS_CTRL_NFD_BIT] != nfd_q);
			for (int c = 0; c < 2; c++)
				cfg_chg_q[c] <= wr_ok && (i_avs_address == `LCS_REG_CFG) &&
					(i_avs_writedata[c*`LCS_CFG_CH_W +: `LCS_CFG_FIELD_W] !=
					cfg_q[c*`LCS_CFG_CH_W +: `LCS_CFG_FIELD_W]);
			if (restore_fire)
			begin
				nfd_q  <= 1'b0;
				cfg_q  <= `LCS_CFG_RST;
				diag_q <= 3'h0;
			end
			else
			begin
				if (wr_ok && i_avs_address == `LCS_REG_CTRL)
				begin
					nfd_q  <= i_avs_writedata[`LCS_CTRL_NFD_BIT];
					diag_q <= i_avs_writedata[`LCS_CTRL_DIAG_LSB +: 3];
				end
				else if (ext_fire_q)
					diag_q <= 3'h0;
				if (wr_ok && i_avs_address == `LCS_REG_CFG)
					cfg_q <= i_avs_writedata[15:0] & 16'h7F7F;
			end
		end
	end

	// Channel reset pulses; diagnostic enables are untouched here
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ch_rst_q <= 2'h3;
		else if (i_ce)
		begin
			for (int c = 0; c < 2; c++)
				ch_rst_q[c] <= dev_rst | cfg_chg_q[c] |
					(hold_fire_q && (sel_q == c[0]));
		end
	end
	assign o_channel_select_button_reset = ch_rst_q;

	// Self-tune: an out-of-range loop holds the channel in tuning
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int c = 0; c < 2; c++)
			begin
				tune_q[c]     <= TUNE_WAIT;
				tune_cnt_q[c] <= 15'h0000;
			end
		end
		else if (i_ce)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (ch_rst_q[c])
				begin
					tune_q[c]     <= TUNE_WAIT;
					tune_cnt_q[c] <= 15'h0000;
				end
				else
				begin
					case (tune_q[c])
						TUNE_WAIT:
						begin
							if (fault_now[c])
								tune_cnt_q[c] <= 15'h0000;
							else if (tick_q && tune_cnt_q[c] == 15'(`LCS_TUNE_MS - 1))
							begin
								tune_q[c]     <= TUNE_OPER;
								tune_cnt_q[c] <= 15'h0000;
							end
							else if (tick_q)
								tune_cnt_q[c] <= tune_cnt_q[c] + 15'h0001;
						end
						TUNE_OPER:
						begin
							if (tick_q && tune_cnt_q[c] ==
								15'(P_FULL_SENS_MS - `LCS_TUNE_MS - 1))
								tune_q[c] <= TUNE_FULL;
							else if (tick_q)
								tune_cnt_q[c] <= tune_cnt_q[c] + 15'h0001;
						end
						TUNE_FULL:
							tune_q[c] <= TUNE_FULL;
						default:
							tune_q[c] <= TUNE_WAIT;
					endcase
				end
			end
		end
	end

	// Fail-safe call, fault message and fault codes
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_call            <= 2'h0;
			o_loop_fail_msg   <= 2'h0;
			o_low_fault_code  <= 2'h0;
			o_high_fault_code <= 2'h0;
			o_delay_abort     <= 2'h0;
			o_operational     <= 2'h0;
			o_full_sens       <= 2'h0;
		end
		else if (i_ce)
		begin
			for (int c = 0; c < 2; c++)
			begin
				// A fault overrides presence or pulse mode alike
				o_call[c] <= fault_now[c] |
					(i_loop_detect[c] & tune_q[c][0]);
				o_loop_fail_msg[c]   <= fault_now[c];
				o_low_fault_code[c]  <= i_loop_short[c] | i_loop_dl_lo[c];
				o_high_fault_code[c] <= i_loop_open[c] | i_loop_dl_hi[c];
				o_delay_abort[c]     <= ~green_n_s[c];
				o_operational[c]     <= tune_q[c][0];
				o_full_sens[c]       <= tune_q[c][1];
			end
		end
	end

	// Fault tally and latched alert; a new failure wins over a clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fault_prev_q <= 2'h0;
			alert_q      <= 2'h0;
			tally_q[0]   <= 8'h00;
			tally_q[1]   <= 8'h00;
		end
		else if (i_ce)
		begin
			fault_prev_q <= fault_now;
			for (int c = 0; c < 2; c++)
			begin
				if (fault_rise[c])
					alert_q[c] <= 1'b1;
				else if (ch_rst_q[c])
					alert_q[c] <= 1'b0;
				// Saturates so a flapping loop never wraps back to a small count
				if (ch_rst_q[c])
					tally_q[c] <= {7'h00, fault_rise[c]};
				else if (fault_rise[c] && tally_q[c] != 8'hFF)
					tally_q[c] <= tally_q[c] + 8'h01;
			end
		end
	end

	// Status pulse trains
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pat_cnt_q[0] <= 8'h00;
			pat_cnt_q[1] <= 8'h00;
			o_status     <= 2'h0;
		end
		else if (i_ce)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (!pat_any[c])
					pat_cnt_q[c] <= 8'h00;
				else if (tick_q && pat_cnt_q[c] == 8'(`LCS_PULSE_ON_MS) +
					lcs_off_ms(i_loop_open[c], i_loop_short[c]) - 8'h01)
					pat_cnt_q[c] <= 8'h00;
				else if (tick_q)
					pat_cnt_q[c] <= pat_cnt_q[c] + 8'h01;
				if (i_det_fail[c])
					o_status[c] <= 1'b1;
				else if (pat_any[c])
					o_status[c] <= (pat_cnt_q[c] >= 8'(`LCS_PULSE_ON_MS));
				else
					o_status[c] <= 1'b0;
			end
		end
	end

	// Flash burst timebase shared by both LEDs
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			flash_cnt_q  <= 7'h00;
			flash_slot_q <= 4'h0;
		end
		else if (i_ce && tick_q)
		begin
			if (flash_cnt_q == 7'(`LCS_FLASH_MS - 1))
			begin
				flash_cnt_q <= 7'h00;
				if (flash_slot_q == 4'(`LCS_FLASH_SLOTS - 1))
					flash_slot_q <= 4'h0;
				else
					flash_slot_q <= flash_slot_q + 4'h1;
			end
			else
				flash_cnt_q <= flash_cnt_q + 7'h01;
		end
	end

	// Detect LEDs; the alert burst hides normal activity until reset
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_led <= 2'h0;
		else if (i_ce)
		begin
			for (int c = 0; c < 2; c++)
				o_led[c] <= alert_q[c] ? burst_on : (o_call[c] | i_delay_active[c] |
					i_ext_active[c] | i_pending[c]);
		end
	end

	// Backlight timeout and display test
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bl_cnt_q       <= 20'h0_0000;
			o_backlight    <= 1'b0;
			o_display_test <= 1'b0;
		end
		else if (i_ce)
		begin
			if (|btn_rise)
				bl_cnt_q <= 20'(P_BACKLIGHT_MS);
			else if (tick_q && bl_cnt_q != 20'h0_0000)
				bl_cnt_q <= bl_cnt_q - 20'h0_0001;
			o_backlight    <= (|btn_rise) | (bl_cnt_q != 20'h0_0000);
			o_display_test <= (lcs_pop4(btn_s) >= 3'h2);
		end
	end

	// Factory restore: all four switches held, any release aborts
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rs_q              <= RS_IDLE;
			rs_cnt_q          <= 13'h0000;
			o_restore_active  <= 1'b0;
			o_restore_left_ms <= 13'h0000;
		end
		else if (i_ce)
		begin
			o_restore_active  <= (rs_q == RS_COUNT);
			o_restore_left_ms <= 13'(P_RESTORE_MS) - rs_cnt_q;
			case (rs_q)
				RS_IDLE:
				begin
					rs_cnt_q <= 13'h0000;
					if (&btn_s)
						rs_q <= RS_COUNT;
				end
				RS_COUNT:
				begin
					if (!(&btn_s))
						rs_q <= RS_IDLE;
					else if (tick_q && rs_cnt_q == 13'(P_RESTORE_MS - 1))
						rs_q <= RS_FIRE;
					else if (tick_q)
						rs_cnt_q <= rs_cnt_q + 13'h0001;
				end
				RS_FIRE:
					rs_q <= RS_DONE;
				RS_DONE:
					if (!(|btn_s))
						rs_q <= RS_IDLE;
				default:
					rs_q <= RS_IDLE;
			endcase
		end
	end

	a_call_on_fault: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && fault_now[0] |=> o_call[0])
		else $error("fault did not force call");
	a_fault_code_lo: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && i_loop_short[0] |=> o_low_fault_code[0] && o_loop_fail_msg[0])
		else $error("low fault code missing");
	a_status_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && !fault_now[0] && !i_det_fail[0] |=> !o_status[0])
		else $error("status not low in normal operation");
	a_status_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && pat_any[0] && !i_det_fail[0] && pat_cnt_q[0] < 8'(`LCS_PULSE_ON_MS)
		|=> !o_status[0])
		else $error("status pulse on time wrong");
	a_ext_reset_all: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && ext_fire_q |=> ch_rst_q == 2'h3 ##1 diag_q == 3'h0 || !i_ce)
		else $error("reset input did not reset both channels");
	a_diag_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && hold_fire_q && !ext_fire_q && !restore_fire && !wr_ok |=> diag_q == $past(diag_q))
		else $error("channel reset changed diagnostics");
	a_tally_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && fault_rise[0] && !ch_rst_q[0] && tally_q[0] != 8'hFF
		|=> tally_q[0] == $past(tally_q[0]) + 8'h01 && alert_q[0])
		else $error("fault tally not incremented");
	a_alert_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && alert_q[0] && !ch_rst_q[0] |=> alert_q[0])
		else $error("alert dropped without reset");
	a_tune_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && tune_q[0] == TUNE_WAIT && fault_now[0] |=> tune_q[0] == TUNE_WAIT)
		else $error("channel tuned with loop out of range");
	a_green_abort: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && !green_n_s[0] |=> o_delay_abort[0])
		else $error("green input did not abort delay");

endmodule : lcs_top

//--- tb/lcs_cabinet.sv
// Cabinet model: pulses the reset pin, passes green and panel switches
`timescale 1ns/10ps
module lcs_cabinet #(
	parameter int P_LOW_CYC = 320
)(
	input  wire logic       i_clk,
	input  wire logic       i_pulse,
	input  wire logic [1:0] i_green_n,
	input  wire logic [3:0] i_btn,
	output logic            o_ext_reset_n,
	output logic [1:0]      o_green_n,
	output logic [3:0]      o_btn
);
	int low_q = 0;
	// Hold a bit over the minimum so tick phase cannot cut it short
	always @(posedge i_clk)
	begin
		if (i_pulse)
			low_q <= P_LOW_CYC;
		else if (low_q != 0)
			low_q <= low_q - 1;
	end
	// Pin low only while the hold count runs; green and switches pass through
	assign o_ext_reset_n = (low_q == 0);
	assign o_green_n     = i_green_n;
	assign o_btn         = i_btn;
endmodule : lcs_cabinet

//--- tb/lcs_top_tb.sv
// Self-checking bench for the loop channel supervisor
`timescale 1ns/10ps
module lcs_top_tb;
	localparam int TK = 10;
	localparam int OFFT[4] = '{50, 100, 150, 150};
	logic        i_sys_clk, i_rst_n, i_avs_read, i_avs_write, i_ext_reset_n, pulse, pl;
	logic        o_avs_waitrequest, o_backlight, o_display_test, o_restore_active;
	logic [1:0]  i_phase_green_n, green_n, i_loop_detect, i_loop_open, i_loop_short;
	logic [1:0]  i_loop_dl_hi, i_loop_dl_lo, i_det_fail, i_delay_active, i_ext_active;
	logic [1:0]  i_pending, o_call, o_status, o_led, o_channel_select_button_reset, o_delay_abort;
	logic [1:0]  o_low_fault_code, o_high_fault_code, o_loop_fail_msg, o_operational;
	logic [1:0]  o_full_sens;
	logic [3:0]  i_btn, btn, i_avs_address;
	logic [12:0] o_restore_left_ms;
	logic [31:0] i_avs_writedata, o_avs_readdata, q;
	int          err_total, total_checks, rc0, rc1, s0, s1, n, k;

	// Short tick and timeouts keep the run brief; expectations scale from TK
	lcs_top #(.P_TICK_CYCLES(TK), .P_FULL_SENS_MS(2100), .P_BACKLIGHT_MS(50), .P_RESTORE_MS(20))
	DUT (
		.i_sys_clk, .i_rst_n, .i_ce(1'b1), .i_ext_reset_n, .i_phase_green_n, .i_btn,
		.i_loop_detect, .i_loop_open, .i_loop_short, .i_loop_dl_hi, .i_loop_dl_lo,
		.i_det_fail, .i_delay_active, .i_ext_active, .i_pending, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
		.o_call, .o_status, .o_led, .o_channel_select_button_reset, .o_delay_abort, .o_low_fault_code,
		.o_high_fault_code, .o_loop_fail_msg, .o_operational, .o_full_sens, .o_backlight,
		.o_display_test, .o_restore_active, .o_restore_left_ms
	);
	lcs_cabinet #(.P_LOW_CYC(32 * TK)) cab (.i_clk(i_sys_clk), .i_pulse(pulse),
		.i_green_n(green_n), .i_btn(btn), .o_ext_reset_n(i_ext_reset_n),
		.o_green_n(i_phase_green_n), .o_btn(i_btn));

	// Clock at 125 MHz
	initial
	begin
		i_sys_clk = 1'b0;
		forever
			#4 i_sys_clk = ~i_sys_clk;
	end

	// Count reset pulses per channel; non-blocking so the main thread never races it
	always @(posedge i_sys_clk)
	begin
		rc0 <= rc0 + int'(o_channel_select_button_reset[0]);
		rc1 <= rc1 + int'(o_channel_select_button_reset[1]);
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tmo();
		err_total++;
		$display("CHECK FAILED wait limit expected done seen timeout");
		print_verdict();
	endtask : tmo

	task automatic cyc(input int c);
		repeat (c) @(posedge i_sys_clk);
	endtask : cyc

	// One bus access; a spare edge after release keeps the old wait-low out of the next one
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int m;
		i_avs_address   <= a;
		i_avs_write     <= w;
		i_avs_read      <= !w;
		i_avs_writedata <= d;
		cyc(1);
		for (m = 0; m < 20 && o_avs_waitrequest !== 1'b0; m++)
			cyc(1);
		if (m == 20)
			tmo();
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
		cyc(1);
	endtask : bus

	task automatic mark();
		s0 = rc0;
		s1 = rc1;
	endtask : mark

	// Wait for any channel reset since mark, then compare which channels saw one
	task automatic wrst(input int lim, input logic [1:0] e, input string nm);
		for (n = 0; n < lim && rc0 == s0 && rc1 == s1; n++)
			cyc(1);
		if (n == lim)
			tmo();
		cyc(4);
		chk(nm, 32'({rc1 != s1, rc0 != s0}), 32'(e));
	endtask : wrst

	// Measure one full high and low phase of channel 0 status
	task automatic pat(input int off);
		for (n = 0; n < 3000 && o_status[0] !== 1'b1; n++)
			cyc(1);
		if (n == 3000)
			tmo();
		for (n = 0; n < 3000 && o_status[0] === 1'b1; n++)
			cyc(1);
		chk("status off", 32'(n), 32'(off * TK));
		for (n = 0; n < 3000 && o_status[0] === 1'b0; n++)
			cyc(1);
		chk("status on", 32'(n), 32'(50 * TK));
	endtask : pat

	// Main sequence
	initial
	begin
		{i_rst_n, pulse, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
		{i_loop_detect, i_loop_open, i_loop_short, i_loop_dl_hi, i_loop_dl_lo} = '0;
		{i_det_fail, i_delay_active, i_ext_active, i_pending, btn} = '0;
		green_n = 2'h3;
		cyc(5);
		chk("wait in reset", 32'(o_avs_waitrequest), 32'h1);
		i_rst_n <= 1'b1;
		cyc(19900);
		chk("early tune", 32'(o_operational), 32'h0);
		cyc(200);
		chk("tuned", 32'(o_operational), 32'h3);
		chk("early sens", 32'(o_full_sens), 32'h0);
		cyc(1000);
		chk("full sens", 32'(o_full_sens), 32'h3);
		green_n <= 2'h2;
		cyc(5);
		chk("green abort", 32'(o_delay_abort), 32'h1);
		green_n <= 2'h3;
		// Each LED source on channel 1 in turn; only detection calls
		for (k = 0; k < 4; k++)
		begin
			{i_pending[1], i_ext_active[1], i_delay_active[1], i_loop_detect[1]} <= 4'h1 << k;
			cyc(4);
			chk("led lit", 32'(o_led[1]), 32'h1);
			chk("call out", 32'(o_call[1]), 32'(k == 0));
		end
		{i_pending[1], i_ext_active[1], i_delay_active[1], i_loop_detect[1]} <= 4'h0;
		// Every loop fault kind on channel 0, healed after each
		for (k = 0; k < 4; k++)
		begin
			{i_loop_dl_lo[0], i_loop_dl_hi[0], i_loop_short[0], i_loop_open[0]} <= 4'h1 << k;
			cyc(4);
			chk("safe call", 32'(o_call), 32'h1);
			chk("fail msg", 32'(o_loop_fail_msg), 32'h1);
			chk("low code", 32'(o_low_fault_code[0]), 32'(k % 2));
			chk("high code", 32'(o_high_fault_code[0]), 32'(k % 2 == 0));
			pat(OFFT[k]);
			{i_loop_dl_lo[0], i_loop_dl_hi[0], i_loop_short[0], i_loop_open[0]} <= 4'h0;
			cyc(4);
			chk("msg gone", 32'(o_loop_fail_msg), 32'h0);
			bus(1'b0, 4'h8, 32'h0);
			chk("alert", 32'(q[2]), 32'h1);
			bus(1'b0, 4'hC, 32'h0);
			chk("tally", q, 32'(k + 1));
		end
		// Rising LED edges over one second of the latched alert
		k = 0;
		for (n = 0; n < 1000 * TK; n++)
		begin
			pl = o_led[0];
			cyc(1);
			k += int'(o_led[0] === 1'b1 && pl === 1'b0);
		end
		chk("bursts", 32'(k), 32'h3);
		i_det_fail <= 2'h1;
		cyc(5);
		for (n = 0; n < 1000 && o_status[0] === 1'b1; n++)
			cyc(1);
		chk("failed steady", 32'(n), 32'd1000);
		i_det_fail <= 2'h0;
		cyc(5);
		chk("normal low", 32'(o_status), 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("cfg reset", q, 32'h7636);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", q, 32'h0);
		bus(1'b0, 4'h6, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, 4'h0, 32'hE);
		mark();
		bus(1'b1, 4'h0, 32'hF);
		wrst(20, 2'h3, "filter reset");
		bus(1'b0, 4'hC, 32'h0);
		chk("tally clear", q, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk("alert clear", 32'(q[3:2]), 32'h0);
		mark();
		bus(1'b1, 4'h4, 32'h6636);
		wrst(20, 2'h2, "cfg reset ch1");
		bus(1'b0, 4'h0, 32'h0);
		chk("diag kept", q, 32'hF);
		mark();
		pulse <= 1'b1;
		cyc(1);
		pulse <= 1'b0;
		wrst(500, 2'h3, "pin reset");
		bus(1'b0, 4'h0, 32'h0);
		chk("diag off", 32'(q[3:1]), 32'h0);
		// Open loop on channel 0 until after the hold reset keeps it out of tuning
		i_loop_open[0] <= 1'b1;
		btn <= 4'h6;
		cyc(8);
		chk("disp test", 32'(o_display_test), 32'h1);
		chk("light on", 32'(o_backlight), 32'h1);
		btn <= 4'h0;
		cyc(400);
		chk("test off", 32'(o_display_test), 32'h0);
		chk("light held", 32'(o_backlight), 32'h1);
		cyc(200);
		chk("light out", 32'(o_backlight), 32'h0);
		mark();
		btn <= 4'h1;
		wrst(31000, 2'h2, "hold reset");
		chk("hold early", 32'(n > 29800), 32'h1);
		chk("no tune", 32'(o_operational), 32'h0);
		i_loop_open[0] <= 1'b0;
		btn <= 4'h0;
		cyc(20);
		btn <= 4'hF;
		cyc(50);
		chk("restore on", 32'(o_restore_active), 32'h1);
		chk("countdown", 32'(o_restore_left_ms > 10 && o_restore_left_ms < 20), 32'h1);
		mark();
		btn <= 4'h0;
		cyc(300);
		chk("abort", 32'({o_restore_active, rc1 != s1, rc0 != s0}), 32'h0);
		btn <= 4'hF;
		wrst(400, 2'h3, "restore reset");
		btn <= 4'h0;
		bus(1'b0, 4'h4, 32'h0);
		chk("defaults", q, 32'h7636);
		print_verdict();
	end
endmodule : lcs_top_tb
